// [verilog/pwr_off_seq_defines.svh]
`ifndef PWR_OFF_SEQ_DEFINES_SVH
`define PWR_OFF_SEQ_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ 50000000
// Fixed detection window, microseconds (within the 10 to 25 ms band)
`define DETECT_US 10000
`define DETECT_CYC ((`DETECT_US * (`CLK_HZ / 1000000)))
// Confirmation delay limit, microseconds
`define CONFIRM_MAX_US 10000
`define CONFIRM_MAX_CYC ((`CONFIRM_MAX_US * (`CLK_HZ / 1000000)))
// Cycles per configuration step of 1 ms
`define CONFIRM_STEP_CYC ((1000 * (`CLK_HZ / 1000000)))
`define CONFIRM_MAX_MS 4'hA
// Power holding time, microseconds
`define HOLD_US 10000
`define HOLD_CYC ((`HOLD_US * (`CLK_HZ / 1000000)))
`define CNT_W 20

`endif

// [verilog/pwr_off_seq_pkg.sv]
package pwr_off_seq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_DETECT  = 5'h02,
    ST_CONFIRM = 5'h04,
    ST_DRAIN   = 5'h08,
    ST_RESET   = 5'h10
  } seq_state_e;

  typedef logic [3:0] delay_ms_t;
endpackage : pwr_off_seq_pkg

// [verilog/power_off_detect_reset_sequencer.sv]
`timescale 1ns/1ns
// Contract
// - Declare loss only after undervoltage held for the full detection window.
// - After declaration, wait configured delay of 0 to 10 ms.
// - Assert module reset when the confirmation delay ends, or once the running instruction finishes if one is busy then.
// - Let the running instruction finish; start no new instruction.
// - Sequence past 10 ms of internal supply holding (always at a 10 ms delay) only raises o_hold_overrun.
// - Arm only in executing modes; on completion stop, outputs off.
// - A dip recovering within 10 ms never declares a loss.
`include "pwr_off_seq_defines.svh"

module power_off_detect_reset_sequencer (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_uv_async,
  input wire logic i_prog_exec,
  input wire pwr_off_seq_pkg::delay_ms_t i_confirm_ms,
  input wire logic i_instr_busy,
  output logic o_instr_start_ok,
  output logic o_outputs_off,
  output logic o_loss_declared,
  output logic o_loss_confirmed,
  output logic o_module_reset,
  output logic o_hold_overrun
);
  import pwr_off_seq_pkg::*;

  // ----------------------------------------------------------------
  // State decoding
  // ----------------------------------------------------------------
  function automatic logic is_declared(input seq_state_e s);
    return (s == ST_CONFIRM) || (s == ST_DRAIN) || (s == ST_RESET);
  endfunction : is_declared

  function automatic logic is_confirmed(input seq_state_e s);
    return (s == ST_DRAIN) || (s == ST_RESET);
  endfunction : is_confirmed

  function automatic logic is_reset(input seq_state_e s);
    return (s == ST_RESET);
  endfunction : is_reset

  // Largest setting times the step still fits the counter width
  function automatic logic [`CNT_W-1:0] ms_to_cyc(input delay_ms_t ms);
    return `CNT_W'(ms) * `CNT_W'(`CONFIRM_STEP_CYC);
  endfunction : ms_to_cyc

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  logic uv_meta;
  logic uv_sync;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uv_meta <= 1'b0;
      uv_sync <= 1'b0;
    end else begin
      uv_meta <= i_uv_async;
      uv_sync <= uv_meta;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  seq_state_e state;
  seq_state_e next_state;
  logic [`CNT_W-1:0] cnt;
  logic [`CNT_W-1:0] next_cnt;
  logic [`CNT_W-1:0] hold_cnt;
  logic [`CNT_W-1:0] confirm_cyc;
  delay_ms_t delay_ms;

  // Oversized settings clamp to the limit rather than wrap
  wire delay_ms_t clamp_ms = (i_confirm_ms > `CONFIRM_MAX_MS) ?
    `CONFIRM_MAX_MS : i_confirm_ms;
  wire detect_done = (cnt == `CNT_W'(`DETECT_CYC - 1));
  // Compares one ahead so the reset lands on the last delay cycle
  wire confirm_done = ((cnt + `CNT_W'(1)) >= confirm_cyc);
  wire hold_done = (hold_cnt == `CNT_W'(`HOLD_CYC - 1));

  always_comb begin
    next_state = state;
    next_cnt = cnt + `CNT_W'(1);
    unique case (state)
      ST_IDLE: begin
        next_cnt = '0;
        if (uv_sync && i_prog_exec) begin
          next_state = ST_DETECT;
        end
      end
      ST_DETECT: begin
        if (!uv_sync || !i_prog_exec) begin
          next_state = ST_IDLE;
          next_cnt = '0;
        end else if (detect_done) begin
          next_cnt = '0;
          // Zero delay confirms on the declaring edge itself
          if (clamp_ms == 4'h0) begin
            next_state = i_instr_busy ? ST_DRAIN : ST_RESET;
          end else begin
            next_state = ST_CONFIRM;
          end
        end
      end
      ST_CONFIRM: begin
        if (confirm_done) begin
          next_state = i_instr_busy ? ST_DRAIN : ST_RESET;
          next_cnt = '0;
        end
      end
      ST_DRAIN: begin
        if (!i_instr_busy) begin
          next_state = ST_RESET;
        end
      end
      ST_RESET: begin
        // Terminal until power-on reset
        next_cnt = cnt;
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Delay capture
  // ----------------------------------------------------------------
  // Delay sampled when the loss is declared, so a late change cannot
  // stretch the sequence past the holding time
  wire take_delay = (state == ST_DETECT) && detect_done && uv_sync &&
    i_prog_exec;

  assign confirm_cyc = ms_to_cyc(delay_ms);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      delay_ms <= 4'h0;
    end else if (take_delay) begin
      delay_ms <= clamp_ms;
    end
  end

  // ----------------------------------------------------------------
  // Holding-time monitor
  // ----------------------------------------------------------------
  // Flags only; forcing reset here would cut the running instruction
  wire hold_active = is_declared(state) && !is_reset(state);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_cnt <= '0;
    end else if (hold_active && !hold_done) begin
      hold_cnt <= hold_cnt + `CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hold_overrun <= 1'b0;
    end else if (hold_active && hold_done) begin
      o_hold_overrun <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  wire declared = is_declared(next_state);
  wire confirmed = is_confirmed(next_state);
  wire entering_reset = is_reset(next_state);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_loss_declared <= 1'b0;
    end else begin
      o_loss_declared <= declared;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_loss_confirmed <= 1'b0;
    end else begin
      o_loss_confirmed <= confirmed;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_module_reset <= 1'b0;
    end else begin
      o_module_reset <= entering_reset;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_instr_start_ok <= 1'b0;
    end else begin
      o_instr_start_ok <= i_prog_exec && !confirmed;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_outputs_off <= 1'b1;
    end else begin
      o_outputs_off <= !i_prog_exec || entering_reset;
    end
  end

endmodule : power_off_detect_reset_sequencer

// [testbench/pwr_off_seq_monitor.sv]
`timescale 1ns/1ns
module pwr_off_seq_monitor (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_uv_async,
  input wire logic i_prog_exec,
  input wire pwr_off_seq_pkg::delay_ms_t i_confirm_ms,
  input wire logic i_instr_busy,
  input wire logic o_instr_start_ok,
  input wire logic o_outputs_off,
  input wire logic o_loss_declared,
  input wire logic o_loss_confirmed,
  input wire logic o_module_reset,
  input wire logic o_hold_overrun
);
  import pwr_off_seq_pkg::*;
  // ----
  // Sequence checks
  // ----
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_conf_free;
    o_loss_confirmed && !i_instr_busy;
  endsequence
  a_decl_needs_uv: assert property ($rose(o_loss_declared) |->
    $past(i_uv_async, 3) && $past(i_prog_exec)) else $error("early loss");
  a_decl_sticky: assert property (
    o_loss_declared |=> o_loss_declared) else $error("declared dropped");
  a_conf_order: assert property (
    o_loss_confirmed |-> o_loss_declared) else $error("confirm early");
  a_reset_order: assert property (
    o_module_reset |-> o_loss_confirmed) else $error("reset early");
  a_reset_prompt: assert property (
    s_conf_free |=> o_module_reset) else $error("reset late");
  a_reset_waits: assert property ($rose(o_module_reset) |->
    !$past(i_instr_busy)) else $error("reset during busy");
  a_no_start: assert property (
    o_loss_confirmed |-> !o_instr_start_ok) else $error("start after loss");
  a_off_reset: assert property (
    o_module_reset |-> o_outputs_off) else $error("outputs on in reset");
endmodule : pwr_off_seq_monitor

// [testbench/mains_monitor_model.sv]
`timescale 1ns/1ns
module mains_monitor_model (
  input wire logic i_low,
  output logic o_uv
);
  // Flag lags the sag and is unrelated to the clock
  assign #3 o_uv = i_low;
endmodule : mains_monitor_model

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
  err_total++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module tb_top;
  import pwr_off_seq_pkg::*;
  logic i_sys_clk = 0, i_rst_n = 0, low = 0;
  logic i_prog_exec = 0, i_instr_busy = 0;
  delay_ms_t i_confirm_ms = 4'h0;
  wire logic i_uv_async;
  logic o_instr_start_ok, o_outputs_off, o_loss_declared;
  logic o_loss_confirmed, o_module_reset, o_hold_overrun;
  int err_total = 0, n_compared = 0, k;
  mains_monitor_model mains (.i_low(low), .o_uv(i_uv_async));
  power_off_detect_reset_sequencer dut (.i_sys_clk, .i_rst_n,
    .i_uv_async, .i_prog_exec, .i_confirm_ms, .i_instr_busy,
    .o_instr_start_ok, .o_outputs_off, .o_loss_declared,
    .o_loss_confirmed, .o_module_reset, .o_hold_overrun);
  initial forever #10 i_sys_clk = ~i_sys_clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cyc
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic t_idle_mode;
    low = 1;
    cyc(600);
    `CHK("outputs_off", 1'b1, o_outputs_off)
    `CHK("declared", 1'b0, o_loss_declared)
    low = 0;
  endtask : t_idle_mode
  task automatic t_dips;
    i_prog_exec = 1;
    cyc(2);
    `CHK("outputs_off run", 1'b0, o_outputs_off)
    // Short dips; a timer that kept counting would shorten the window
    // measured in the loss scenario that follows
    repeat (2) begin
      low = 1;
      cyc(5000);
      low = 0;
      cyc(10);
    end
    `CHK("dip declared", 1'b0, o_loss_declared)
    `CHK("start_ok", 1'b1, o_instr_start_ok)
  endtask : t_dips
  task automatic t_loss;
    i_confirm_ms = 4'h1;
    i_instr_busy = 1;
    low = 1;
    k = 0;
    while (!o_loss_declared && k < 600000) begin
      cyc(1);
      k++;
    end
    `CHK("window", 1'b1, k >= 500000 && k < 510000)
    `CHK("confirmed early", 1'b0, o_loss_confirmed)
    k = 0;
    while (!o_loss_confirmed && k < 60000) begin
      cyc(1);
      k++;
    end
    `CHK("delay cycles", 50000, k)
    cyc(5);
    `CHK("reset busy", 1'b0, o_module_reset)
    `CHK("start_ok", 1'b0, o_instr_start_ok)
    i_instr_busy = 0;
    cyc(2);
    `CHK("reset", 1'b1, o_module_reset)
    `CHK("hold_overrun", 1'b0, o_hold_overrun)
    `CHK("outputs_off", 1'b1, o_outputs_off)
  endtask : t_loss
  task automatic t_mid_reset;
    low = 0;
    i_rst_n = 0;
    cyc(2);
    `CHK("reset held", 1'b0, o_module_reset)
    `CHK("declared held", 1'b0, o_loss_declared)
    i_rst_n = 1;
    cyc(1);
    `CHK("start_ok rerun", 1'b1, o_instr_start_ok)
    `CHK("outputs_off rerun", 1'b0, o_outputs_off)
  endtask : t_mid_reset
  initial begin
    cyc(16);
    i_rst_n = 1;
    t_idle_mode();
    t_dips();
    t_loss();
    t_mid_reset();
    summarize();
  end
endmodule : tb_top
bind power_off_detect_reset_sequencer pwr_off_seq_monitor mon (.i_sys_clk,
  .i_rst_n, .i_uv_async, .i_prog_exec, .i_confirm_ms, .i_instr_busy,
  .o_instr_start_ok, .o_outputs_off, .o_loss_declared,
  .o_loss_confirmed, .o_module_reset, .o_hold_overrun);
